// >>> inc/tmcr_pkg.sv
/*
 tmcr_pkg: shared constants and types of the thermal monitor register slice
 (extended readout, third configuration, throttle timer status and limit).
 Assumes a 10 MHz system clock; tick and tach times are converted from it, the seen limit from the tick.
*/
package tmcr_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_EXT_LSBS = 8'h77;
   localparam logic [7:0] ADDR_CFG3 = 8'h78;
   localparam logic [7:0] ADDR_THR_STATUS = 8'h79;
   localparam logic [7:0] ADDR_THR_LIMIT = 8'h7A;

   // ==========================================================
   // values after reset
   localparam logic [7:0] CFG3_RESET = 8'h00;
   localparam logic [7:0] THR_STATUS_RESET = 8'h00;
   localparam logic [7:0] THR_LIMIT_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ==========================================================
   // times and cycle counts
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS = 22_760_000;
   localparam int SEEN_LIMIT_NS = 45_520_000;
   localparam int TACH_SLOW_NS = 1_000_000_000;
   localparam int TACH_FAST_NS = 250_000_000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   localparam int TACH_SLOW_CYC = TACH_SLOW_NS / CLK_PERIOD_NS;
   localparam int TACH_FAST_CYC = TACH_FAST_NS / CLK_PERIOD_NS;
   localparam logic [7:0] TIMER_MIN_TICKS = 8'(SEEN_LIMIT_NS / TICK_NS);
   localparam logic [7:0] TIMER_MAX = 8'hFF;
   localparam int CNT_W = 24;

   // ==========================================================
   // field layouts
   typedef struct packed {
      logic [3:0] cont_tach;
      logic fast;
      logic boost;
      logic mon_en;
      logic alert;
   } tmcr_cfg3_t;

   typedef struct packed {
      logic [1:0] remote_two_temp_lsbs;
      logic [1:0] local_temp_lsbs;
      logic [1:0] remote_one_temp_lsbs;
      logic [1:0] supply_12v_lsbs;
   } tmcr_ext_lsbs_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } tmcr_req_t;

endpackage

// >>> hw/tmcr_throttle_timer.sv
/*
 tmcr_throttle_timer: measures how long the throttle signal stays asserted,
 builds the status byte and flags a limit overrun once per assertion.
 Assumes i_active is already synchronised to clk.
*/
`timescale 1ns/1ps
module tmcr_throttle_timer #(
   parameter int TICK_CYC = tmcr_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic i_active,
   input wire logic i_read_clear,
   input wire logic [7:0] i_limit,
   // results
   output logic [7:0] o_status,
   output logic o_event
);
   logic [tmcr_pkg::CNT_W-1:0] pre;
   logic [7:0] count;
   logic seen;
   logic prev_active;
   logic done;
   logic event_q;

   // ==========================================================
   // decode
   wire start = i_active & ~prev_active;
   wire tick = i_active & ~start &
      (pre == tmcr_pkg::CNT_W'(TICK_CYC - 1));
   wire [7:0] cnt_now = start ? 8'h00 : count;
   wire over = (i_limit == 8'h00) | (cnt_now > i_limit);
   wire fire = i_active & (start | ~done) & over;
   wire [7:0] next_count = start ? 8'h00 :
      (tick && count != tmcr_pkg::TIMER_MAX) ? count + 8'h01 : count;
   wire [tmcr_pkg::CNT_W-1:0] next_pre = (!i_active || start || tick) ?
      '0 : pre + tmcr_pkg::CNT_W'(1);

   // ==========================================================
   // state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre <= '0;
         count <= 8'h00;
         seen <= 1'b0;
         prev_active <= 1'b0;
         done <= 1'b0;
         event_q <= 1'b0;
      end else begin
         pre <= next_pre;
         count <= next_count;
         seen <= start | (seen & ~i_read_clear);
         prev_active <= i_active;
         done <= start ? fire : (done | fire);
         event_q <= fire;
      end
   end

   assign o_status = (count >= tmcr_pkg::TIMER_MIN_TICKS) ?
      count : {7'h00, seen};
   assign o_event = event_q;

   // ==========================================================
   // checks
   a_count_saturates: assert property (@(posedge clk) disable iff (!rst_n)
      count == 8'hFF && i_active && !start |=> count == 8'hFF)
      else $error("throttle count wrapped");
   a_limit_zero_event: assert property (@(posedge clk) disable iff (!rst_n)
      start && i_limit == 8'h00 |=> o_event)
      else $error("zero limit gave no event at assertion");
endmodule // tmcr_throttle_timer

// >>> hw/tmcr_regs.sv
/*
 tmcr_regs: register slice of the hardware monitor holding the second
 extended readout, the third configuration, throttle status and limit.
 Assumes the bus engine hands over decoded one-cycle read and write
 strobes on the system clock; measurement, lock and pin-select inputs
 come from logic on the same clock; throttle pins are asynchronous.
*/
// Summary of operation
// - reading extended LSBs freezes them and MSBs
// - read-only LSB pairs: 12V, remote1, local, remote2
// - bit 0 turns fan-two pin into alert
// - bit 1 enables throttle monitor on selected pin
// - boost forces all fans full on assertion
// - fast bit: tach every 250 ms, else 1 s
// - bits 4-7 enable continuous tach per channel
// - lock makes configuration three read only
// - status bit 0 set on assertion, read clears
// - upper timer bits zero until 45.52 ms
// - then 8-bit count, 22.76 ms steps, to 5.80 s
// - power-up clears config, status and limit
// - count above limit raises throttle event
`timescale 1ns/1ps
module tmcr_regs #(
   parameter int TICK_CYC = tmcr_pkg::TICK_CYC,
   parameter int TACH_SLOW_CYC = tmcr_pkg::TACH_SLOW_CYC,
   parameter int TACH_FAST_CYC = tmcr_pkg::TACH_FAST_CYC
) (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   // register access
   input wire tmcr_pkg::tmcr_req_t I_REG_REQ,
   output logic [7:0] O_REG_RDATA,
   output logic O_REG_VALID,
   // measurement readout
   input wire tmcr_pkg::tmcr_ext_lsbs_t I_MEAS_LSBS,
   input wire logic I_MSB_READ,
   output logic O_FREEZE,
   // device context
   input wire logic I_CFG_LOCK,
   input wire logic I_THROTTLE_PIN_SELECT,
   input wire logic I_OUT_OF_LIMIT,
   input wire logic I_FAN2_PWM,
   // throttle pins, active low
   input wire logic I_THROTTLE_TACH4_N,
   input wire logic I_THROTTLE_5V_N,
   // fan and tach control
   output logic O_SECOND_FAN_DRIVE_PIN_O,
   output logic O_SECOND_FAN_DRIVE_PIN_OE,
   output logic O_FULL_SPEED,
   output logic O_TACH_START,
   output logic [3:0] O_CONT_TACH,
   output logic O_THROTTLE_EVENT
);
   // ==========================================================
   // reset release
   logic [1:0] rst_pipe;
   logic rst_n;
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // ==========================================================
   // pin synchronisers
   logic [1:0] sync_a;
   logic [1:0] sync_b;
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 2'b11;
         sync_b <= 2'b11;
      end else begin
         sync_a <= {sync_a[0], I_THROTTLE_TACH4_N};
         sync_b <= {sync_b[0], I_THROTTLE_5V_N};
      end
   end

   // ==========================================================
   // registers
   tmcr_pkg::tmcr_cfg3_t cfg3;
   tmcr_pkg::tmcr_ext_lsbs_t ext_lsbs;
   logic [7:0] limit;
   logic frozen;
   logic [7:0] status_val;
   logic timer_event;

   wire [7:0] addr = I_REG_REQ.addr;
   wire wr = I_REG_REQ.wr;
   wire rd = I_REG_REQ.rd;
   wire wr_cfg3 = wr & (addr == tmcr_pkg::ADDR_CFG3) & ~I_CFG_LOCK;
   wire wr_limit = wr & (addr == tmcr_pkg::ADDR_THR_LIMIT);
   wire rd_ext = rd & (addr == tmcr_pkg::ADDR_EXT_LSBS);
   wire rd_status = rd & (addr == tmcr_pkg::ADDR_THR_STATUS);
   wire next_frozen = rd_ext | (frozen & ~I_MSB_READ);

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg3 <= tmcr_pkg::CFG3_RESET;
         limit <= tmcr_pkg::THR_LIMIT_RESET;
         ext_lsbs <= '0;
         frozen <= 1'b0;
      end else begin
         if (wr_cfg3) begin
            cfg3 <= I_REG_REQ.wdata;
         end
         if (wr_limit) begin
            limit <= I_REG_REQ.wdata;
         end
         if (!frozen) begin
            ext_lsbs <= I_MEAS_LSBS;
         end
         frozen <= next_frozen;
      end
   end

   // ==========================================================
   // throttle monitor
   wire pin_level_n = I_THROTTLE_PIN_SELECT ? sync_b[1] : sync_a[1];
   wire thr_active = cfg3.mon_en & ~pin_level_n;

   tmcr_throttle_timer #(
      .TICK_CYC(TICK_CYC)
   ) u_timer (
      .clk(I_SYS_CLK),
      .rst_n(rst_n),
      .i_active(thr_active),
      .i_read_clear(rd_status),
      .i_limit(limit),
      .o_status(status_val),
      .o_event(timer_event)
   );

   // ==========================================================
   // tach measurement period
   logic [tmcr_pkg::CNT_W-1:0] tach_cnt;
   wire [tmcr_pkg::CNT_W-1:0] tach_last = cfg3.fast ?
      tmcr_pkg::CNT_W'(TACH_FAST_CYC - 1) :
      tmcr_pkg::CNT_W'(TACH_SLOW_CYC - 1);
   wire tach_wrap = tach_cnt >= tach_last;

   // ==========================================================
   // read mux
   wire [7:0] rd_mux = (addr == tmcr_pkg::ADDR_EXT_LSBS) ? ext_lsbs :
      (addr == tmcr_pkg::ADDR_CFG3) ? cfg3 :
      (addr == tmcr_pkg::ADDR_THR_STATUS) ? status_val :
      (addr == tmcr_pkg::ADDR_THR_LIMIT) ? limit :
      tmcr_pkg::UNMAPPED_READ;

   // ==========================================================
   // output drive
   wire full = cfg3.boost & thr_active;
   wire next_pin_o = cfg3.alert ? 1'b0 : (I_FAN2_PWM | full);
   wire next_pin_oe = cfg3.alert ? I_OUT_OF_LIMIT : 1'b1;

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_REG_RDATA <= tmcr_pkg::RDATA_RESET;
         O_REG_VALID <= 1'b0;
         O_FREEZE <= 1'b0;
         O_SECOND_FAN_DRIVE_PIN_O <= 1'b0;
         O_SECOND_FAN_DRIVE_PIN_OE <= 1'b0;
         O_FULL_SPEED <= 1'b0;
         O_TACH_START <= 1'b0;
         O_CONT_TACH <= 4'h0;
         O_THROTTLE_EVENT <= 1'b0;
         tach_cnt <= '0;
      end else begin
         O_REG_RDATA <= rd ? rd_mux : O_REG_RDATA;
         O_REG_VALID <= rd;
         O_FREEZE <= next_frozen;
         O_SECOND_FAN_DRIVE_PIN_O <= next_pin_o;
         O_SECOND_FAN_DRIVE_PIN_OE <= next_pin_oe;
         O_FULL_SPEED <= full;
         O_TACH_START <= tach_wrap;
         O_CONT_TACH <= cfg3.cont_tach;
         O_THROTTLE_EVENT <= timer_event;
         tach_cnt <= tach_wrap ? '0 : tach_cnt + tmcr_pkg::CNT_W'(1);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!rst_n);

   a_lock_blocks_write: assert property (
      wr && addr == tmcr_pkg::ADDR_CFG3 && I_CFG_LOCK |=> $stable(cfg3))
      else $error("locked config register changed");
   a_cfg_write_lands: assert property (
      wr && addr == tmcr_pkg::ADDR_CFG3 && !I_CFG_LOCK
      |=> cfg3 == $past(I_REG_REQ.wdata))
      else $error("config write lost");
   a_freeze_holds: assert property (
      rd_ext |=> O_FREEZE && frozen)
      else $error("extended readout not frozen after read");
   a_freeze_stable: assert property (
      frozen |=> $stable(ext_lsbs))
      else $error("extended readout moved while frozen");
   a_ext_tracks_live: assert property (
      !frozen |=> ext_lsbs == $past(I_MEAS_LSBS))
      else $error("extended readout not following measurement");
   a_alert_pin_mode: assert property (
      cfg3.alert && I_OUT_OF_LIMIT |=> O_SECOND_FAN_DRIVE_PIN_OE
      && !O_SECOND_FAN_DRIVE_PIN_O)
      else $error("alert not pulled on fan two pin");
   a_boost_full_speed: assert property (
      cfg3.boost && cfg3.mon_en && !pin_level_n |=> O_FULL_SPEED)
      else $error("boost failed to force full speed");
   a_monitor_gated: assert property (
      !cfg3.mon_en [*2] |=> !O_FULL_SPEED && !O_THROTTLE_EVENT)
      else $error("throttle acted while monitor disabled");
   a_seen_on_assert: assert property (
      $rose(thr_active) |=> status_val[0])
      else $error("assertion not flagged in status");
   a_upper_bits_zero: assert property (
      $rose(thr_active) |=> (status_val[7:1] == 7'h00) [*8])
      else $error("timer bits shown below threshold");
   a_tach_period_fast: assert property (
      O_TACH_START |-> $past(tach_cnt) >=
      tmcr_pkg::CNT_W'(TACH_FAST_CYC - 1))
      else $error("tach start came before a full fast period");
   a_read_answer: assert property (
      rd |=> O_REG_VALID && O_REG_RDATA == $past(rd_mux))
      else $error("read answer missing");
endmodule // tmcr_regs

// >>> bench/tmcr_host_model.sv
/*
 tmcr_host_model: host side of the register port, one-cycle strobes.
 Assumes the slice answers one cycle after the read strobe edge.
*/
`timescale 1ns/1ps
module tmcr_host_model (
   // clock
   input wire logic i_clk,
   // answer from the slice
   input wire logic [7:0] i_rdata,
   input wire logic i_valid,
   // request to the slice
   output tmcr_pkg::tmcr_req_t o_req
);
   initial o_req = '0;
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] wd);
      @(posedge i_clk);
      o_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: wd};
      @(posedge i_clk);
      o_req <= '0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge i_clk);
      o_req <= '0;
      @(posedge i_clk);
      // data only counts with its valid pulse
      d = (i_valid === 1'b1) ? i_rdata : 8'hXX;
   endtask
endmodule // tmcr_host_model

// >>> bench/tmcr_regs_bench.sv
/*
 tmcr_regs_bench: self-checking bench of the register slice.
 Assumes shortened tick (20) and tach periods (40 slow, 10 fast).
*/
`timescale 1ns/1ps
module tmcr_regs_bench;
   typedef struct {logic w; logic [7:0] a, wd, e;} tmcr_row_t;
   logic clk = 0, rst_n = 0, lock = 0, psel = 0, ool = 0, pwm = 0;
   logic msb = 0, t4_n = 1, t5_n = 1, valid, frz, fo, foe, full, tst, ev;
   logic [7:0] rdata, d;
   logic [3:0] cont;
   tmcr_pkg::tmcr_ext_lsbs_t meas = 8'hE4;
   tmcr_pkg::tmcr_req_t req;
   int bad_count = 0, checks_done = 0, cyc = 0, evn = 0, tn = 0, t0, e0;
   tmcr_row_t rows[8] = '{'{0, 8'h78, 8'h00, 8'h00},
      '{0, 8'h79, 8'h00, 8'h00}, '{0, 8'h7A, 8'h00, 8'h00},
      '{1, 8'h78, 8'hF0, 8'hF0}, '{1, 8'h7A, 8'h3C, 8'h3C},
      '{1, 8'h79, 8'h55, 8'h00}, '{1, 8'h7B, 8'hAA, 8'h00},
      '{1, 8'h77, 8'hFF, 8'hE4}};

   tmcr_regs #(.TICK_CYC(20), .TACH_SLOW_CYC(40), .TACH_FAST_CYC(10))
   tmcr_regs_inst (.I_SYS_CLK(clk), .I_RSTN(rst_n), .I_REG_REQ(req),
      .O_REG_RDATA(rdata), .O_REG_VALID(valid), .I_MEAS_LSBS(meas),
      .I_MSB_READ(msb), .O_FREEZE(frz), .I_CFG_LOCK(lock),
      .I_THROTTLE_PIN_SELECT(psel), .I_OUT_OF_LIMIT(ool),
      .I_FAN2_PWM(pwm), .I_THROTTLE_TACH4_N(t4_n), .I_THROTTLE_5V_N(t5_n),
      .O_SECOND_FAN_DRIVE_PIN_O(fo), .O_SECOND_FAN_DRIVE_PIN_OE(foe),
      .O_FULL_SPEED(full), .O_TACH_START(tst), .O_CONT_TACH(cont),
      .O_THROTTLE_EVENT(ev));
   tmcr_host_model tmcr_host_model_inst (.i_clk(clk), .i_rdata(rdata),
      .i_valid(valid), .o_req(req));

   // ==========================================================
   // clock, pulse counters and hang guard
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ev === 1'b1) evn <= evn + 1;
      if (tst === 1'b1) tn <= tn + 1;
      if (cyc == 12000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ==========================================================
   // helpers
   task chk(input logic [7:0] got, input logic [7:0] exp, input string s);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input string s);
      tmcr_host_model_inst.rd_reg(a, d);
      chk(d, e, s);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] wd);
      tmcr_host_model_inst.wr_reg(a, wd);
   endtask
   task at(input int n);
      while (cyc < t0 + n) @(posedge clk);
   endtask
   task do_reset;
      @(posedge clk) rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task pulse_msb;
      @(posedge clk) msb <= 1'b1;
      @(posedge clk) msb <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      do_reset();
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].wd);
         rd(rows[i].a, rows[i].e, "row");
      end
      chk({4'h0, cont}, 8'h0F, "cont tach");
      @(posedge clk) lock <= 1'b1;
      wr(8'h78, 8'h00);
      rd(8'h78, 8'hF0, "locked");
      @(posedge clk) lock <= 1'b0;
      // freeze and release
      pulse_msb();
      chk(frz, 0, "unfrozen");
      rd(8'h77, 8'hE4, "lsb map");
      chk(frz, 1, "frozen");
      @(posedge clk) meas <= 8'h1B;
      repeat (3) @(posedge clk);
      rd(8'h77, 8'hE4, "held");
      pulse_msb();
      chk(frz, 0, "released");
      rd(8'h77, 8'h1B, "live");
      // tach start rate, fast then slow
      wr(8'h78, 8'hF8);
      e0 = tn;
      repeat (200) @(posedge clk);
      chk(8'((tn - e0) inside {[19:21]}), 1, "fast rate");
      wr(8'h78, 8'hF0);
      e0 = tn;
      repeat (200) @(posedge clk);
      chk(8'((tn - e0) inside {[4:6]}), 1, "slow rate");
      // alert pin against fan drive
      wr(8'h78, 8'h01);
      @(posedge clk) ool <= 1'b1;
      repeat (3) @(posedge clk);
      chk({6'h00, foe, fo}, 8'h02, "alert on");
      @(posedge clk) ool <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h00, foe}, 8'h00, "alert off");
      wr(8'h78, 8'h00);
      @(posedge clk) pwm <= 1'b1;
      repeat (3) @(posedge clk);
      chk({6'h00, foe, fo}, 8'h03, "fan mode");
      // reset in mid-run, with config three and limit away from zero
      wr(8'h7A, 8'h3C);
      wr(8'h78, 8'hF0);
      do_reset();
      for (int i = 0; i < 3; i++) rd(rows[i].a, 8'h00, "rst");
      chk({4'h0, cont}, 8'h00, "rst cont");
      // throttle with monitoring off
      @(posedge clk) t4_n <= 1'b0;
      repeat (30) @(posedge clk);
      rd(8'h79, 8'h00, "mon off");
      @(posedge clk) t4_n <= 1'b1;
      // timer with boost, limit three
      wr(8'h7A, 8'h03);
      wr(8'h78, 8'h06);
      @(posedge clk) t4_n <= 1'b0;
      t0 = cyc;
      e0 = evn;
      at(8);
      rd(8'h79, 8'h01, "seen");
      rd(8'h79, 8'h00, "cleared");
      chk(full, 1, "boost");
      at(30);
      rd(8'h79, 8'h00, "count 1 hidden");
      at(50);
      rd(8'h79, 8'h02, "count 2");
      at(75);
      chk(8'(evn - e0), 0, "early event");
      at(90);
      rd(8'h79, 8'h04, "count 4");
      chk(8'(evn - e0), 1, "event");
      at(5300);
      rd(8'h79, 8'hFF, "saturate");
      @(posedge clk) t4_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk(full, 0, "boost end");
      rd(8'h79, 8'hFF, "held");
      chk(8'(evn - e0), 1, "one event");
      // zero limit on the 5 V pin
      @(posedge clk) psel <= 1'b1;
      wr(8'h7A, 8'h00);
      wr(8'h78, 8'h02);
      e0 = evn;
      @(posedge clk) t5_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk(8'(evn - e0), 1, "zero limit");
      chk(full, 0, "no boost");
      report_and_stop();
   end
endmodule // tmcr_regs_bench
